/* core/udvsc_stepped_gain_control.sv */
// Stepped gain control: 64-position gain index driven by push pins.
// Assumes asynchronous pins; each passes two flip-flops before use.
// Operation
// - Step tick is the base oscillator divided by 2 to the 13th.
// - Base oscillator nominally 200 kHz, tick about 24 Hz.
// - After 3.5 ticks held low, gain index moves one step.
// - A low pulse released before 3.5 ticks gives no step.
// - Held low, second step comes 9.5 ticks after the first.
// - Held further, each next step comes every 2 ticks.
// - Gain index has 64 positions, 1 to 64.
// - Each position selects a fixed gain from -75.0 to 23.8 dB.
// - Power-on or reset pin low loads position 13 (2.6 dB).
// - The reset pin is active low.
// - Both volume pins high: no change, partial timing discarded.
// - Mute low disables outputs, high enables them.
// - Mute switches outputs at once, no ramp.
// - Leaving mute keeps the gain index held before mute.
// - An undriven mute pin reads high.
// - Power-off low turns amp and outputs off, gain steps go on; undriven power-off reads low.
`timescale 1ns/10ps
module udvsc_stepped_gain_control #(
  parameter int OSC_DIV = udvsc_pkg::OSC_DIV,
  parameter int OSC_PER_TICK = udvsc_pkg::OSC_PER_TICK
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pins, asynchronous, sampled through two flip-flops
  input wire udvsc_pkg::udvsc_pins_type pins,
  // Gain and output control
  output logic [6:0] gain_index,
  output logic outputs_enable,
  output logic amp_enable,
  output logic step_pulse
);
  typedef struct packed {
    udvsc_pkg::udvsc_pins_type sync1;
    udvsc_pkg::udvsc_pins_type sync2;
    udvsc_pkg::udvsc_phase_type phase;
    logic dir_up;
    logic [7:0] halves;
    logic [6:0] gain;
    logic out_en;
    logic amp_en;
    logic step;
  } udvsc_state_type;

  udvsc_state_type state_reg;
  udvsc_state_type state_next;
  logic half_tick;
  logic one_low;
  logic up_req;
  logic clear_div;
  logic turn_dir;

  // pin pulls are modelled by the pad: the testbench drives
  // mute high and power-off low when the pins float.
  assign up_req = ~state_reg.sync2.up_n;
  assign one_low = state_reg.sync2.up_n ^ state_reg.sync2.volume_down_n;
  // A turn of direction restarts the divider, so the new pin waits in full
  assign turn_dir = state_reg.phase != udvsc_pkg::UDVSC_IDLE &&
      state_reg.dir_up != up_req;
  assign clear_div = ~one_low | turn_dir;

  udvsc_tick_div #(
    .OSC_DIV(OSC_DIV),
    .OSC_PER_TICK(OSC_PER_TICK)
  ) u_div (
    .clk(clk),
    .rst(rst),
    .clear(clear_div),
    .half_tick(half_tick)
  );

  always_comb begin
    state_next = state_reg;
    state_next.sync1 = pins;
    state_next.sync2 = state_reg.sync1;
    state_next.step = 1'b0;
    state_next.out_en = state_reg.sync2.mute_n;
    state_next.amp_en = state_reg.sync2.power_off_n;
    if (!state_reg.sync2.reset_n) begin
      state_next.gain = udvsc_pkg::GAIN_DEFAULT;
      state_next.phase = udvsc_pkg::UDVSC_IDLE;
      state_next.halves = '0;
    end else if (!one_low) begin
      state_next.phase = udvsc_pkg::UDVSC_IDLE;
      state_next.halves = '0;
    end else begin
      if (state_reg.phase == udvsc_pkg::UDVSC_IDLE ||
          state_reg.dir_up != up_req) begin
        state_next.phase = udvsc_pkg::UDVSC_FIRST;
        state_next.dir_up = up_req;
        state_next.halves = '0;
      end else if (half_tick) begin
        state_next.halves = state_reg.halves + 8'h01;
        case (state_reg.phase)
          udvsc_pkg::UDVSC_FIRST: begin
            if (state_next.halves == udvsc_pkg::FIRST_HALVES) begin
              state_next.step = 1'b1;
              state_next.phase = udvsc_pkg::UDVSC_SECOND;
              state_next.halves = '0;
            end
          end
          udvsc_pkg::UDVSC_SECOND: begin
            if (state_next.halves == udvsc_pkg::SECOND_HALVES) begin
              state_next.step = 1'b1;
              state_next.phase = udvsc_pkg::UDVSC_REPEAT;
              state_next.halves = '0;
            end
          end
          udvsc_pkg::UDVSC_REPEAT: begin
            if (state_next.halves == udvsc_pkg::REPEAT_HALVES) begin
              state_next.step = 1'b1;
              state_next.halves = '0;
            end
          end
          default: begin
            state_next.phase = udvsc_pkg::UDVSC_IDLE;
          end
        endcase
      end
      if (state_next.step) begin
        if (up_req && state_reg.gain != udvsc_pkg::GAIN_MAX) begin
          state_next.gain = state_reg.gain + 7'h01;
        end else if (!up_req && state_reg.gain != udvsc_pkg::GAIN_MIN) begin
          state_next.gain = state_reg.gain - 7'h01;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg.sync1 <= udvsc_pkg::PINS_IDLE;
      state_reg.sync2 <= udvsc_pkg::PINS_IDLE;
      state_reg.phase <= udvsc_pkg::UDVSC_IDLE;
      state_reg.dir_up <= 1'b0;
      state_reg.halves <= 8'h00;
      state_reg.gain <= udvsc_pkg::GAIN_DEFAULT;
      state_reg.out_en <= 1'b0;
      state_reg.amp_en <= 1'b0;
      state_reg.step <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign gain_index = state_reg.gain;
  assign outputs_enable = state_reg.out_en & state_reg.amp_en;
  assign amp_enable = state_reg.amp_en;
  assign step_pulse = state_reg.step;

  a_gain_range: assert property (@(posedge clk) disable iff (rst)
    gain_index >= 7'h01 && gain_index <= 7'h40)
    else $error("gain index out of range");
  a_reset_default: assert property (@(posedge clk) disable iff (rst)
    !state_reg.sync2.reset_n |=> gain_index == 7'h0D)
    else $error("reset did not load default gain");
  a_idle_hold: assert property (@(posedge clk) disable iff (rst)
    !one_low && state_reg.sync2.reset_n |=> $stable(gain_index))
    else $error("gain moved with no single pin low");
  a_both_low: assert property (@(posedge clk) disable iff (rst)
    !state_reg.sync2.up_n && !state_reg.sync2.volume_down_n
    |=> !step_pulse)
    else $error("step with both pins low");
  a_step_one: assert property (@(posedge clk) disable iff (rst)
    step_pulse && state_reg.sync2.reset_n && gain_index != 7'h01
    && gain_index != 7'h40 |-> gain_index != $past(gain_index))
    else $error("step did not move gain");
  a_sat_top: assert property (@(posedge clk) disable iff (rst)
    $past(gain_index) == 7'h40 && step_pulse && state_reg.dir_up
    |-> gain_index == 7'h40)
    else $error("gain passed the top");
  a_mute_fast: assert property (@(posedge clk) disable iff (rst)
    !state_reg.sync2.mute_n |=> !outputs_enable)
    else $error("mute did not disable outputs");
  a_mute_gain: assert property (@(posedge clk) disable iff (rst)
    $fell(state_reg.sync2.mute_n) && one_low == 1'b0
    |=> $stable(gain_index))
    else $error("mute changed gain");
  a_power_off: assert property (@(posedge clk) disable iff (rst)
    !state_reg.sync2.power_off_n |=> !amp_enable)
    else $error("power off ignored");

  // Step direction, width, cause and output gating
  a_sat_bottom: assert property (@(posedge clk) disable iff (rst)
    $past(gain_index) == 7'h01 && step_pulse && !state_reg.dir_up
    |-> gain_index == 7'h01)
    else $error("gain passed the bottom");
  a_step_up: assert property (@(posedge clk) disable iff (rst)
    step_pulse && state_reg.dir_up && $past(gain_index) != 7'h40
    |-> gain_index == $past(gain_index) + 7'h01)
    else $error("up step did not add one");
  a_step_down: assert property (@(posedge clk) disable iff (rst)
    step_pulse && !state_reg.dir_up && $past(gain_index) != 7'h01
    |-> gain_index == $past(gain_index) - 7'h01)
    else $error("down step did not take one");
  a_step_width: assert property (@(posedge clk) disable iff (rst)
    step_pulse |=> !step_pulse)
    else $error("step pulse longer than one cycle");
  a_reset_hold: assert property (@(posedge clk) disable iff (rst)
    !state_reg.sync2.reset_n |=> !step_pulse)
    else $error("step while reset pin low");
  a_gain_cause: assert property (@(posedge clk) disable iff (rst)
    $changed(gain_index)
    |-> step_pulse || !$past(state_reg.sync2.reset_n))
    else $error("gain changed with no step or reset");
  a_turn_wait: assert property (@(posedge clk) disable iff (rst)
    one_low && turn_dir && state_reg.sync2.reset_n |=> !step_pulse)
    else $error("step at a turn of direction");
  a_half_gap: assert property (@(posedge clk) disable iff (rst)
    half_tick |=> !half_tick)
    else $error("half tick longer than one cycle");
  a_unmute: assert property (@(posedge clk) disable iff (rst)
    state_reg.sync2.mute_n && state_reg.sync2.power_off_n
    |=> outputs_enable)
    else $error("outputs not enabled");
  a_power_gate: assert property (@(posedge clk) disable iff (rst)
    !state_reg.sync2.power_off_n |=> !outputs_enable)
    else $error("outputs on while powered off");
  a_power_on: assert property (@(posedge clk) disable iff (rst)
    state_reg.sync2.power_off_n |=> amp_enable)
    else $error("amplifier not powered");
endmodule

/* include/udvsc_pkg.sv */
// Constants and carriers for the stepped gain control block.
// Assumes a single 250 MHz core clock and pins synchronised in the core.
package udvsc_pkg;
  // Core clock and base oscillator
  localparam int CLK_HZ = 250000000;
  localparam int BASE_OSC_HZ = 200000;
  // Core cycles per base oscillator cycle
  localparam int OSC_DIV = CLK_HZ / BASE_OSC_HZ;
  localparam int TICK_SHIFT = 13;
  localparam int OSC_PER_TICK = 2 ** TICK_SHIFT;
  // Delays in half ticks: 3.5, 9.5 and 2 ticks
  localparam logic [7:0] FIRST_HALVES = 8'h07;
  localparam logic [7:0] SECOND_HALVES = 8'h13;
  localparam logic [7:0] REPEAT_HALVES = 8'h04;
  // Gain index, positions 1 to 64
  localparam logic [6:0] GAIN_MIN = 7'h01;
  localparam logic [6:0] GAIN_MAX = 7'h40;
  localparam logic [6:0] GAIN_DEFAULT = 7'h0D;

  typedef enum logic [1:0] {
    UDVSC_IDLE,
    UDVSC_FIRST,
    UDVSC_SECOND,
    UDVSC_REPEAT
  } udvsc_phase_type;

  typedef struct packed {
    logic up_n;
    logic volume_down_n;
    logic mute_n;
    logic power_off_n;
    logic reset_n;
  } udvsc_pins_type;
  // Pin levels at rest: volume pins high, mute high, power-off low
  localparam udvsc_pins_type PINS_IDLE = 5'h1D;
endpackage

/* core/udvsc_tick_div.sv */
// Divider that makes the half-tick enable of the stepped gain control.
// Assumes clk at the core rate; the output is a one-cycle pulse.
`timescale 1ns/10ps
module udvsc_tick_div #(
  parameter int OSC_DIV = udvsc_pkg::OSC_DIV,
  parameter int OSC_PER_TICK = udvsc_pkg::OSC_PER_TICK
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic clear,
  output logic half_tick
);
  localparam int HALF_CYC = OSC_DIV * (OSC_PER_TICK / 2);
  localparam int CW = $clog2(HALF_CYC + 1);

  typedef struct packed {
    logic [CW-1:0] count;
    logic pulse;
  } udvsc_div_type;

  udvsc_div_type state_reg;
  udvsc_div_type state_next;

  always_comb begin
    state_next = state_reg;
    state_next.pulse = 1'b0;
    if (clear) begin
      state_next.count = '0;
    end else if (state_reg.count == CW'(HALF_CYC - 1)) begin
      state_next.count = '0;
      state_next.pulse = 1'b1;
    end else begin
      state_next.count = state_reg.count + CW'(1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign half_tick = state_reg.pulse;
endmodule

/* test/udvsc_push_model.sv */
// Push-button model driving the control pins of the gain block.
// Assumes the bench calls push and sets the other pins at falling edges.
`timescale 1ns/10ps
module udvsc_push_model (
  // Clock
  input wire logic clk,
  // Control pins
  output udvsc_pkg::udvsc_pins_type pins
);
  // Floating levels: mute pulled high, power-off pulled low
  initial begin
    pins = 5'h1D;
  end
  // One low pulse of n cycles on one or both volume pins
  task automatic push(input logic up, input logic dn, input int n);
    @(negedge clk);
    pins.up_n = ~up;
    pins.volume_down_n = ~dn;
    repeat (n) @(negedge clk);
    pins.up_n = 1'b1;
    pins.volume_down_n = 1'b1;
  endtask
  // Up low n_up cycles, then down low n_dn cycles with no gap between
  task automatic turn(input int n_up, input int n_dn);
    @(negedge clk);
    pins.up_n = 1'b0;
    repeat (n_up) @(negedge clk);
    pins.up_n = 1'b1;
    pins.volume_down_n = 1'b0;
    repeat (n_dn) @(negedge clk);
    pins.volume_down_n = 1'b1;
  endtask
endmodule

/* test/updown_volume_step_control_tb_top.sv */
// Testbench of the stepped gain control, with a push-button model.
// Assumes a half tick of 4 clocks (OSC_DIV 2, OSC_PER_TICK 4).
`timescale 1ns/10ps
module updown_volume_step_control_tb_top;
  logic clk;
  logic rst;
  udvsc_pkg::udvsc_pins_type pins;
  logic [6:0] gain_index;
  logic outputs_enable;
  logic amp_enable;
  logic step_pulse;
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;
  int eg = 13;
  int k;
  int q[$];

  udvsc_push_model pm_u (.clk(clk), .pins(pins));
  udvsc_stepped_gain_control #(.OSC_DIV(2), .OSC_PER_TICK(4)) dut_u (
    .clk(clk), .rst(rst), .pins(pins), .gain_index(gain_index),
    .outputs_enable(outputs_enable), .amp_enable(amp_enable),
    .step_pulse(step_pulse));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Cycle stamps of every gain step
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (step_pulse === 1'b1) q.push_back(cyc);
  end

  task automatic chk(input logic [6:0] exp, input logic [6:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic close_out();
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Hold n cycles; steps is the count the step timing gives for n
  task automatic run(input logic up, input logic dn, input int n,
      input int steps);
    q.delete();
    pm_u.push(up, dn, n);
    repeat (8) @(negedge clk);
    for (int i = 0; i < steps; i++) begin
      if (up && eg < 64) eg++;
      if (dn && eg > 1) eg--;
    end
    chk(7'(eg), gain_index);
    chk(7'(steps), 7'(q.size()));
  endtask

  // Up for 22 cycles, then turned to down: down waits 3.5 ticks in full
  task automatic turn_run(input int n, input int steps);
    q.delete();
    pm_u.turn(22, n);
    repeat (8) @(negedge clk);
    eg = eg - steps;
    chk(7'(eg), gain_index);
    chk(7'(steps), 7'(q.size()));
  endtask

  initial begin
    repeat (8000) @(posedge clk);
    n_mismatch++;
    $display("timeout at %0t", $time);
    close_out();
  end

  initial begin
    rst = 1'b1;
    k = $urandom(32'hB959);
    repeat (3) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    chk(7'h0D, gain_index);
    chk(7'h00, 7'(amp_enable));
    pm_u.pins.power_off_n = 1'b1;
    repeat (4) @(negedge clk);
    chk(7'h01, 7'(amp_enable));
    chk(7'h01, 7'(outputs_enable));
    $display("test reset done");
    run(1'b1, 1'b0, 20, 0);
    run(1'b1, 1'b0, 20, 0);
    run(1'b1, 1'b0, 60, 1);
    $display("test single done");
    k = 1 + $urandom % 5;
    run(1'b0, 1'b1, 115 + 16 * k, k + 2);
    chk(7'h4C, 7'(q[1] - q[0]));
    chk(7'h10, 7'(q[2] - q[1]));
    run(1'b1, 1'b1, 300, 0);
    turn_run(27, 0);
    turn_run(40, 1);
    $display("test turn done");
    $display("test repeat done");
    run(1'b1, 1'b0, 1075, 62);
    pm_u.pins.mute_n = 1'b0;
    repeat (4) @(negedge clk);
    chk(7'h00, 7'(outputs_enable));
    pm_u.pins.mute_n = 1'b1;
    repeat (4) @(negedge clk);
    chk(7'h01, 7'(outputs_enable));
    chk(7'h40, gain_index);
    run(1'b0, 1'b1, 1203, 70);
    $display("test mute and ends done");
    pm_u.pins.reset_n = 1'b0;
    repeat (4) @(negedge clk);
    chk(7'h0D, gain_index);
    pm_u.pins.reset_n = 1'b1;
    pm_u.pins.power_off_n = 1'b0;
    repeat (4) @(negedge clk);
    chk(7'h00, 7'(amp_enable));
    chk(7'h00, 7'(outputs_enable));
    $display("test pins done");
    close_out();
  end
endmodule
